// >>> inc/spi_cmd_pkg.sv
// Shared constants for the sensor SPI command decoder
package spi_cmd_pkg;
   // Frame and register file sizes
   localparam int WORD_BITS  = 16;
   localparam int FRAME_BITS = 32;
   localparam int REG_COUNT  = 64;
   localparam int BLOCK_REGS = 32;
   // Command words and codes
   localparam logic [7:0]  CMD_READ_CODE = 8'hD2;
   localparam logic [15:0] CMD_WRITE     = 16'hEA54;
   localparam logic [15:0] CMD_STORE     = 16'hEA55;
   localparam logic [15:0] CMD_BLOCK0    = 16'hEA00;
   localparam logic [15:0] CMD_BLOCK1    = 16'hEA01;
   localparam logic [15:0] CMD_RESTORE   = 16'hEA56;
   localparam logic [15:0] CMD_CLEAR     = 16'hD700;
   // Register addresses and field positions
   localparam logic [7:0] ADDR_ERRORS    = 8'h1A;
   localparam logic [7:0] ADDR_CONFIG    = 8'h1C;
   localparam int         BIT_TURN_SEL   = 7;
   localparam int         BIT_PARITY     = 0;
   localparam int         BIT_MEM_ERR    = 1;
   localparam int         BIT_CHECKSUM   = 2;
   localparam int         BIT_MEM_BUSY   = 3;
   // Timing
   localparam longint CLK_HZ         = 100000000;
   localparam longint STORE_MS       = 600;
   localparam longint RESTORE_US     = 240;
   localparam longint STORE_CYCLES   = (STORE_MS * CLK_HZ + 999) / 1000;
   localparam longint RESTORE_CYCLES = (RESTORE_US * CLK_HZ + 999999) / 1000000;
   // Reset values
   localparam logic [31:0] REPLY_RESET = 32'h0000_0000;
endpackage : spi_cmd_pkg

// >>> logic/spi_link_shifter.sv
// Link-side shift logic running on the controller's SPI clock
`timescale 1ns/10ps
`default_nettype none
module spi_link_shifter
(
   // Link pins
   input  wire logic        spiClk,
   input  wire logic        csN,
   input  wire logic        copi,
   output logic             cipo,
   output logic             cipoOe,
   // Core side
   input  wire logic        nrst,
   input  wire logic [31:0] reply,
   output logic [15:0]      rxWord,
   output logic             frameTgl,
   output logic             overTgl
);
   logic [5:0]  rxCnt;
   logic [4:0]  outIdx;
   logic [15:0] rxShift;
   logic        rstAsync;

   assign rstAsync = ~nrst;

   // Counters clear while chip select is high, so no edge outside a frame is needed
   always_ff @(posedge spiClk or posedge csN)
   begin
      if (csN)
         rxCnt <= 6'h00;
      else if (rxCnt != 6'h3F)
         rxCnt <= rxCnt + 6'h01;
   end

   // Output index follows the rising-edge count; in mode 3 the extra leading falling edge sees zero
   always_ff @(negedge spiClk or posedge csN)
   begin
      if (csN)
         outIdx <= 5'h00;
      else if (rxCnt < 6'h20)
         outIdx <= rxCnt[4:0];
      else
         outIdx <= 5'h1F;
   end

   always_ff @(posedge spiClk)
   begin
      rxShift <= {rxShift[14:0], copi};
      if (!csN && rxCnt == 6'h0F)
         rxWord <= {rxShift[14:0], copi};
   end

   // Toggles mark a complete word and any bit beyond it
   always_ff @(posedge spiClk or posedge rstAsync)
   begin
      if (rstAsync)
      begin
         frameTgl <= 1'b0;
         overTgl  <= 1'b0;
      end
      else if (!csN)
      begin
         if (rxCnt == 6'h0F)
            frameTgl <= ~frameTgl;
         if (rxCnt == 6'h10)
            overTgl <= ~overTgl;
      end
   end

   assign cipoOe = csN;
   assign cipo   = csN ? 1'b0 : reply[5'h1F - outIdx];
endmodule // spi_link_shifter
`default_nettype wire

// >>> logic/sensor_spi_command_decoder.sv
// SPI command interpreter: frame sequencing, register file and non-volatile store
`timescale 1ns/10ps
`default_nettype none
module sensor_spi_command_decoder
#(
   parameter longint STORE_CYCLES   = spi_cmd_pkg::STORE_CYCLES,
   parameter longint RESTORE_CYCLES = spi_cmd_pkg::RESTORE_CYCLES
)
(
   // Core clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // SPI link
   input  wire logic        spiClk,
   input  wire logic        csN,
   input  wire logic        copi,
   output logic             cipo,
   output logic             cipoOe,
   // Sensor data
   input  wire logic [15:0] angle,
   input  wire logic [15:0] turnCount,
   input  wire logic [15:0] speed,
   input  wire logic        checksumFault,
   // Status
   output logic             turnOrSpeedSelect,
   output logic             memoryBusyFlag,
   output logic             memoryCommandErrorFlag,
   output logic             memoryChecksumErrorFlag,
   output logic             parityErrorFlag
);
   typedef enum logic [7:0] {
      IDLE         = 8'h01,
      READ_REPLY   = 8'h02,
      WRITE_FRAME  = 8'h04,
      WRITE_ECHO   = 8'h08,
      STORE_SELECT = 8'h10,
      STORE_ZERO   = 8'h20,
      RESTORE_ZERO = 8'h40,
      CLEAR_ZERO   = 8'h80
   } seq_t;

   typedef struct packed {
      seq_t        seq;
      logic [2:0]  csSync;
      logic [2:0]  frameSync;
      logic [2:0]  overSync;
      logic        csLvl;
      logic        frameLvl;
      logic        overLvl;
      logic        frameSeen;
      logic        overSeen;
      logic [7:0]  addr;
      logic        memErr;
      logic        crcErr;
      logic        copying;
      logic        restoring;
      logic        block;
      logic [5:0]  copyIdx;
      logic [31:0] hold;
      logic        busy;
      logic [31:0] reply;
   } state_t;

   localparam logic [31:0] STORE_HOLD   = 32'(STORE_CYCLES);
   localparam logic [31:0] RESTORE_HOLD = 32'(RESTORE_CYCLES);

   state_t     s;
   state_t     next_s;
   logic [7:0] workReg [spi_cmd_pkg::REG_COUNT];
   logic [7:0] nvm     [spi_cmd_pkg::REG_COUNT];
   logic       memWr;
   logic [5:0] memAddr;
   logic [7:0] memData;
   logic       nvmWr;
   logic [5:0] nvmAddr;
   logic [15:0] rxWord;
   logic       frameTgl;
   logic       overTgl;
   logic       csRise;
   logic       fullWord;
   logic       nvmFree;
   logic       turnSel;
   logic [7:0] errByte;

   spi_link_shifter u_link
   (
      .spiClk   (spiClk),
      .csN      (csN),
      .copi     (copi),
      .cipo     (cipo),
      .cipoOe   (cipoOe),
      .nrst     (nrst),
      .reply    (s.reply),
      .rxWord   (rxWord),
      .frameTgl (frameTgl),
      .overTgl  (overTgl)
   );

   // Register 26 view; parity checking is not built, so its flag stays clear
   always_comb
   begin
      errByte = 8'h00;
      errByte[spi_cmd_pkg::BIT_MEM_BUSY] = s.busy;
      errByte[spi_cmd_pkg::BIT_CHECKSUM] = s.crcErr;
      errByte[spi_cmd_pkg::BIT_MEM_ERR]  = s.memErr;
      errByte[spi_cmd_pkg::BIT_PARITY]   = 1'b0;
   end

   function automatic logic [7:0] readReg(input logic [7:0] a, input logic [7:0] errs, input logic [7:0] val);
      if (a == spi_cmd_pkg::ADDR_ERRORS)
         readReg = errs;
      else if (a < 8'(spi_cmd_pkg::REG_COUNT))
         readReg = val;
      else
         readReg = 8'h00;
   endfunction

   assign turnSel = workReg[spi_cmd_pkg::ADDR_CONFIG[5:0]][spi_cmd_pkg::BIT_TURN_SEL];
   assign nvmFree = !s.copying && s.hold == 32'h0000_0000;

   always_comb
   begin
      next_s  = s;
      memWr   = 1'b0;
      memAddr = 6'h00;
      memData = 8'h00;
      nvmWr   = 1'b0;
      nvmAddr = 6'h00;
      // Three-stage synchronisers; a level moves once stages two and three agree
      next_s.csSync    = {s.csSync[1:0], csN};
      next_s.frameSync = {s.frameSync[1:0], frameTgl};
      next_s.overSync  = {s.overSync[1:0], overTgl};
      if (s.csSync[1] == s.csSync[2])
         next_s.csLvl = s.csSync[2];
      if (s.frameSync[1] == s.frameSync[2])
         next_s.frameLvl = s.frameSync[2];
      if (s.overSync[1] == s.overSync[2])
         next_s.overLvl = s.overSync[2];
      csRise   = !s.csLvl && s.csSync[1] == s.csSync[2] && s.csSync[2];
      fullWord = s.frameLvl != s.frameSeen && s.overLvl == s.overSeen;

      // Non-volatile engine: one register per cycle, then a guard interval
      if (s.copying)
      begin
         if (s.restoring)
         begin
            memWr   = 1'b1;
            memAddr = s.copyIdx;
            memData = nvm[s.copyIdx];
         end
         else
         begin
            nvmWr   = 1'b1;
            nvmAddr = {s.block, s.copyIdx[4:0]};
         end
         next_s.copyIdx = s.copyIdx + 6'h01;
         if ((s.restoring && s.copyIdx == 6'(spi_cmd_pkg::REG_COUNT - 1)) ||
             (!s.restoring && s.copyIdx == 6'(spi_cmd_pkg::BLOCK_REGS - 1)))
         begin
            next_s.copying = 1'b0;
            next_s.hold    = s.restoring ? RESTORE_HOLD : STORE_HOLD;
         end
      end
      else if (s.hold != 32'h0000_0000)
         next_s.hold = s.hold - 32'h0000_0001;

      // Command sequencing at each frame end
      if (csRise)
      begin
         next_s.frameSeen = s.frameLvl;
         next_s.overSeen  = s.overLvl;
         next_s.seq       = IDLE;
         if (fullWord)
         begin
            case (s.seq)
               IDLE:
               begin
                  if (rxWord[15:8] == spi_cmd_pkg::CMD_READ_CODE)
                  begin
                     next_s.addr = rxWord[7:0];
                     next_s.seq  = READ_REPLY;
                  end
                  else if (rxWord == spi_cmd_pkg::CMD_WRITE)
                     next_s.seq = WRITE_FRAME;
                  else if (rxWord == spi_cmd_pkg::CMD_STORE)
                     next_s.seq = STORE_SELECT;
                  else if (rxWord == spi_cmd_pkg::CMD_RESTORE)
                     next_s.seq = RESTORE_ZERO;
                  else if (rxWord == spi_cmd_pkg::CMD_CLEAR)
                     next_s.seq = CLEAR_ZERO;
                  else
                     next_s.seq = IDLE;
               end
               WRITE_FRAME:
               begin
                  next_s.addr = rxWord[15:8];
                  next_s.seq  = WRITE_ECHO;
                  if (rxWord[15:8] < 8'(spi_cmd_pkg::REG_COUNT) && rxWord[15:8] != spi_cmd_pkg::ADDR_ERRORS &&
                      !s.copying)
                  begin
                     memWr   = 1'b1;
                     memAddr = rxWord[13:8];
                     memData = rxWord[7:0];
                  end
               end
               STORE_SELECT:
               begin
                  if (rxWord == spi_cmd_pkg::CMD_BLOCK0 || rxWord == spi_cmd_pkg::CMD_BLOCK1)
                  begin
                     next_s.seq = STORE_ZERO;
                     if (nvmFree)
                     begin
                        next_s.copying   = 1'b1;
                        next_s.restoring = 1'b0;
                        next_s.block     = rxWord[0];
                        next_s.copyIdx   = 6'h00;
                     end
                     else
                        next_s.memErr = 1'b1;
                  end
               end
               RESTORE_ZERO:
               begin
                  if (nvmFree)
                  begin
                     next_s.copying   = 1'b1;
                     next_s.restoring = 1'b1;
                     next_s.copyIdx   = 6'h00;
                  end
                  else
                     next_s.memErr = 1'b1;
               end
               CLEAR_ZERO:
               begin
                  next_s.memErr = 1'b0;
                  next_s.crcErr = 1'b0;
               end
               default:
                  next_s.seq = IDLE;
            endcase
         end
      end
      if (checksumFault)
         next_s.crcErr = 1'b1;
      next_s.busy = next_s.copying || next_s.hold != 32'h0000_0000;

      // Reply only moves while select is high; a frame sees a frozen word
      if (s.csLvl && !csRise)
      begin
         case (s.seq)
            READ_REPLY, WRITE_ECHO:
               next_s.reply = {angle[15:8], readReg(s.addr, errByte, workReg[s.addr[5:0]]), 16'h0000};
            default:
               next_s.reply = {angle, turnSel ? speed : turnCount};
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         s           <= '0;
         s.seq       <= IDLE;
         s.csSync    <= 3'h7;
         s.csLvl     <= 1'b1;
         s.copying   <= 1'b1;
         s.restoring <= 1'b1;
         s.busy      <= 1'b1;
         s.reply     <= spi_cmd_pkg::REPLY_RESET;
      end
      else
         s <= next_s;
   end

   // Stored contents are non-volatile, so neither array is cleared by reset
   always_ff @(posedge core_clk)
   begin
      if (memWr)
         workReg[memAddr] <= memData;
      if (nvmWr)
         nvm[nvmAddr] <= workReg[nvmAddr];
   end

   assign turnOrSpeedSelect       = turnSel;
   assign memoryBusyFlag          = s.busy;
   assign memoryCommandErrorFlag  = s.memErr;
   assign memoryChecksumErrorFlag = s.crcErr;
   assign parityErrorFlag         = errByte[spi_cmd_pkg::BIT_PARITY];
endmodule // sensor_spi_command_decoder
`default_nettype wire

// >>> verif/sensor_spi_command_decoder_props.sv
// Assertions on the command decoder's pins and status flags
`timescale 1ns/10ps
`default_nettype none
module sensor_spi_command_decoder_props
#(
   parameter longint STORE_CYCLES   = spi_cmd_pkg::STORE_CYCLES,
   parameter longint RESTORE_CYCLES = spi_cmd_pkg::RESTORE_CYCLES
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Link
   input wire logic csN,
   input wire logic cipo,
   input wire logic cipoOe,
   // Status
   input wire logic checksumFault,
   input wire logic turnOrSpeedSelect,
   input wire logic memoryBusyFlag,
   input wire logic memoryCommandErrorFlag,
   input wire logic memoryChecksumErrorFlag,
   input wire logic parityErrorFlag
);
   // Busy time so far, to bound the guard interval from below
   logic [31:0] busyLen;
   always_ff @(posedge core_clk)
   begin
      if (!nrst || !memoryBusyFlag)
         busyLen <= '0;
      else
         busyLen <= busyLen + 32'h1;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   chk_oe_tracks_cs: assert property (cipoOe == csN)
      else $error("output enable differs from chip select");
   chk_cipo_idle: assert property (csN |-> !cipo)
      else $error("data out not low while deselected");
   chk_parity_clear: assert property (!parityErrorFlag)
      else $error("parity flag raised without parity support");
   chk_checksum_sets: assert property (checksumFault |=> memoryChecksumErrorFlag)
      else $error("checksum fault not flagged");
   chk_err_fall_frame: assert property ($fell(memoryCommandErrorFlag) |-> $past(csN, 3))
      else $error("memory error flag cleared inside a frame");
   chk_err_when_busy: assert property ($rose(memoryCommandErrorFlag) |-> $past(memoryBusyFlag))
      else $error("memory error raised while memory idle");
   chk_busy_guard: assert property ($fell(memoryBusyFlag) |-> busyLen >= RESTORE_CYCLES)
      else $error("busy interval too short");
   chk_busy_after_frame: assert property ($rose(memoryBusyFlag) |-> csN && $past(csN))
      else $error("memory operation started inside a frame");
   chk_select_frame: assert property ($changed(turnOrSpeedSelect) |-> csN && $past(csN, 2))
      else $error("select bit changed inside a frame");
endmodule // sensor_spi_command_decoder_props
bind sensor_spi_command_decoder sensor_spi_command_decoder_props #(
   .STORE_CYCLES(STORE_CYCLES),
   .RESTORE_CYCLES(RESTORE_CYCLES)
) chk_u (.core_clk, .nrst, .csN, .cipo, .cipoOe, .checksumFault, .turnOrSpeedSelect,
   .memoryBusyFlag, .memoryCommandErrorFlag, .memoryChecksumErrorFlag, .parityErrorFlag);
`default_nettype wire

// >>> verif/spi_ctrl_model.sv
// SPI controller model that clocks frames in mode 0 or mode 3
`timescale 1ns/10ps
`default_nettype none
module spi_ctrl_model
(
   // Link pins
   output logic     spiClk,
   output logic     csN,
   output logic     copi,
   input wire logic cipo
);
   // Clock idle level; the bench picks it per command
   logic mode3 = 1'b0;
   initial
   begin
      csN = 1'b1;
      copi = 1'b0;
      spiClk = 1'b0;
   end
   // One frame framed by chip select, link clock still outside it
   task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
      rx = '0;
      spiClk = mode3;
      #40 csN = 1'b0;
      #20;
      for (int i = n - 1; i >= 0; i--)
      begin
         spiClk = 1'b0;
         copi = tx[i];
         #15 spiClk = 1'b1;
         rx = {rx[30:0], cipo};
         #15;
      end
      spiClk = mode3;
      #20 csN = 1'b1;
      // Released line must not keep showing the last bit
      copi = ~copi;
      #150;
   endtask
endmodule // spi_ctrl_model
`default_nettype wire

// >>> verif/sensor_spi_command_decoder_bench.sv
// Self-checking bench for the sensor SPI command decoder
`timescale 1ns/10ps
`default_nettype none
module sensor_spi_command_decoder_bench;
   logic        core_clk, nrst, checksumFault;
   logic [15:0] angle, turnCount, speed;
   logic        spiClk, csN, copi, cipo, cipoOe;
   logic        turnOrSpeedSelect, memoryBusyFlag, memoryCommandErrorFlag;
   logic        memoryChecksumErrorFlag, parityErrorFlag;
   logic [31:0] rx, expW;
   int          regs[64], nvm[64];
   int          bad_count, total_checks;

   // Long store interval shortened so a second command lands inside it
   sensor_spi_command_decoder #(.STORE_CYCLES(400), .RESTORE_CYCLES(20)) dut_u
      (.core_clk, .nrst, .spiClk, .csN, .copi, .cipo, .cipoOe, .angle, .turnCount, .speed,
       .checksumFault, .turnOrSpeedSelect, .memoryBusyFlag, .memoryCommandErrorFlag,
       .memoryChecksumErrorFlag, .parityErrorFlag);
   spi_ctrl_model ctl_u (.spiClk, .csN, .copi, .cipo);

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic end_sim();
      $display("Checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chkW(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error %0t reply %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkF(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic frame(input logic [15:0] w);
      ctl_u.xfer(16, {16'h0000, w}, rx);
   endtask
   // New sensor values, settled before the frame freezes them
   task automatic fresh();
      @(posedge core_clk);
      angle <= 16'($urandom);
      turnCount <= 16'($urandom);
      speed <= 16'($urandom);
      repeat (10) @(posedge core_clk);
   endtask
   task automatic wr(input int a, input int v);
      fresh();
      frame(spi_cmd_pkg::CMD_WRITE);
      frame({a[7:0], v[7:0]});
      frame(16'h0000);
      regs[a] = v;
      chkW(rx, {16'h0000, angle[15:8], 8'(regs[a])});
   endtask
   task automatic rd(input int a);
      fresh();
      frame({spi_cmd_pkg::CMD_READ_CODE, a[7:0]});
      frame(16'h0000);
      chkW(rx, {16'h0000, angle[15:8], 8'(regs[a])});
   endtask
   task automatic nv(input logic [15:0] w, input int blk);
      fresh();
      frame(w);
      if (blk >= 0)
         frame(blk[0] ? spi_cmd_pkg::CMD_BLOCK1 : spi_cmd_pkg::CMD_BLOCK0);
      frame(16'h0000);
      chkW(rx, {16'h0000, angle});
   endtask
   task automatic waitIdle();
      for (int i = 0; i < 3000 && memoryBusyFlag !== 1'b0; i++)
         @(posedge core_clk);
      chkF(memoryBusyFlag, 1'b0);
   endtask

   initial
   begin
      #400us;
      bad_count++;
      end_sim();
   end

   initial
   begin
      void'($urandom(46));
      {nrst, checksumFault, angle, turnCount, speed} = '0;
      bad_count = 0;
      total_checks = 0;
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      waitIdle();
      chkF(memoryCommandErrorFlag, 1'b0);
      for (int a = 0; a < 64; a++)
      begin
         ctl_u.mode3 = a[0];
         if (a != 26)
            wr(a, $urandom_range(255));
      end
      chkF(turnOrSpeedSelect, regs[28][7]);
      for (int s = 0; s < 2; s++)
      begin
         wr(28, s * 128);
         fresh();
         expW = {angle, s ? speed : turnCount};
         // Sensor values move mid-frame; the reply must stay frozen
         fork
            ctl_u.xfer(32, 32'h0000_0000, rx);
            begin
               repeat (12) @(posedge core_clk);
               angle     <= ~angle;
               turnCount <= ~turnCount;
               speed     <= ~speed;
            end
         join
         chkW(rx, expW);
      end
      fresh();
      frame(16'h1234);
      frame(16'h0000);
      chkW(rx, {16'h0000, angle});
      for (int a = 0; a < 64; a++)
      begin
         ctl_u.mode3 = a[1];
         if (a != 26)
            rd(a);
      end
      nv(spi_cmd_pkg::CMD_STORE, 0);
      for (int i = 0; i < 32; i++)
         nvm[i] = regs[i];
      chkF(memoryBusyFlag, 1'b1);
      nv(spi_cmd_pkg::CMD_RESTORE, -1);
      chkF(memoryCommandErrorFlag, 1'b1);
      waitIdle();
      nv(spi_cmd_pkg::CMD_STORE, 1);
      for (int i = 32; i < 64; i++)
         nvm[i] = regs[i];
      waitIdle();
      @(posedge core_clk);
      checksumFault <= 1'b1;
      @(posedge core_clk);
      checksumFault <= 1'b0;
      @(posedge core_clk);
      chkF(memoryChecksumErrorFlag, 1'b1);
      nv(spi_cmd_pkg::CMD_CLEAR, -1);
      chkF(memoryCommandErrorFlag, 1'b0);
      chkF(memoryChecksumErrorFlag, 1'b0);
      chkF(parityErrorFlag, 1'b0);
      wr(5, 255 - regs[5]);
      wr(40, 255 - regs[40]);
      wr(28, 255 - regs[28]);
      nv(spi_cmd_pkg::CMD_RESTORE, -1);
      waitIdle();
      regs = nvm;
      rd(5);
      rd(40);
      chkF(turnOrSpeedSelect, regs[28][7]);
      chkF(cipoOe, 1'b1);
      end_sim();
   end
endmodule // sensor_spi_command_decoder_bench
`default_nettype wire
